/* hdl/aen_pkg.sv */
/*
  aen_pkg: register indices, field positions, reset values and widths
  for the audio enhancement control block.
  assumes: apb byte address is four times the register index.
*/
package aen_pkg;

   // ***************************************
   // register indices (byte address = 4 x index)
   // ***************************************
   localparam logic [15:0] IDX_ADC_EXTRA   = 16'h0017;
   localparam logic [15:0] IDX_WIDEN       = 16'h010c;
   localparam logic [15:0] IDX_PROC_PWR    = 16'h0300;
   localparam logic [15:0] IDX_PROC_EXEC   = 16'h040d;
   localparam logic [15:0] IDX_ROUTE       = 16'h0410;
   localparam logic [15:0] IDX_STATUS      = 16'h0411;
   localparam logic [15:0] IDX_ENH_EN      = 16'h4005;
   localparam logic [15:0] IDX_COEF_FIRST  = 16'h4200;
   localparam logic [15:0] IDX_COEF_LAST   = 16'h5293;
   localparam int          COEF_SLOTS      = 4244;

   // ***************************************
   // field positions
   // ***************************************
   localparam int BIT_OSR_HIGH     = 5;
   localparam int BIT_WIDEN_EN     = 0;
   localparam int BIT_MONOMIX      = 6;
   localparam int BIT_PROC_EN      = 0;
   localparam int BIT_RUN_CMD      = 1;
   localparam int BIT_STOP_CMD     = 2;
   localparam int BIT_DRC_EN       = 0;
   localparam int BIT_DRC_IN_DAC   = 1;
   localparam int BIT_DRC_SIDECHN  = 2;
   localparam int ENH_ADC_FLAT     = 0;
   localparam int ENH_DAC_FLAT     = 1;
   localparam int ENH_BASS         = 2;
   localparam int ENH_HPF_A        = 3;
   localparam int ENH_HPF_B        = 4;
   localparam int ENH_VSS          = 5;
   localparam int ENH_BITS         = 6;

   // ***************************************
   // reset values
   // ***************************************
   localparam logic [15:0] RST_ADC_EXTRA = 16'h0000;
   localparam logic [15:0] RST_WIDEN     = 16'h0000;
   localparam logic        RST_PROC_EN   = 1'b0;
   localparam logic [2:0]  RST_ROUTE     = 3'h0;
   localparam logic [5:0]  RST_ENH_EN    = 6'h00;

   localparam int SAMPLE_W = 24;

endpackage

/* hdl/aen_if.sv */
/*
  aen_if: carries the adc sample stream and its controls from the
  control block to the mix path.
  assumes: both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface aen_if;
   logic                              in_valid;
   logic signed [aen_pkg::SAMPLE_W-1:0] in_left;
   logic signed [aen_pkg::SAMPLE_W-1:0] in_right;
   logic                              monomix_on;
   logic                              out_valid;
   logic signed [aen_pkg::SAMPLE_W-1:0] out_left;
   logic signed [aen_pkg::SAMPLE_W-1:0] out_right;

   modport ctrl (output in_valid, in_left, in_right, monomix_on,
                 input out_valid, out_left, out_right);
   modport path (input in_valid, in_left, in_right, monomix_on,
                 output out_valid, out_left, out_right);
endinterface

`default_nettype wire

/* hdl/aen_mix_path.sv */
/*
  aen_mix_path: adc stereo sample stage with optional mono mix.
  assumes: samples arrive one pair per in_valid on sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module aen_mix_path
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic clk_en,
   // stream
   aen_if.path       mp
);

   // ***************************************
   // mono mix
   // ***************************************
   // 25 bit sum cannot overflow; halving it is the 6 dB cut
   wire logic signed [aen_pkg::SAMPLE_W:0]   sum_full;
   wire logic signed [aen_pkg::SAMPLE_W-1:0] mix_half;
   assign sum_full = {mp.in_left[aen_pkg::SAMPLE_W-1], mp.in_left}
                   + {mp.in_right[aen_pkg::SAMPLE_W-1], mp.in_right};
   assign mix_half = sum_full[aen_pkg::SAMPLE_W:1];

   logic                              valid_reg;
   logic signed [aen_pkg::SAMPLE_W-1:0] left_reg;
   logic signed [aen_pkg::SAMPLE_W-1:0] right_reg;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         valid_reg <= 1'b0;
         left_reg  <= '0;
         right_reg <= '0;
      end
      else if (clk_en)
      begin
         valid_reg <= mp.in_valid;
         if (mp.in_valid)
         begin
            left_reg  <= mp.monomix_on ? mix_half : mp.in_left;
            right_reg <= mp.monomix_on ? mix_half : mp.in_right;
         end
      end
   end

   assign mp.out_valid = valid_reg;
   assign mp.out_left  = left_reg;
   assign mp.out_right = right_reg;

endmodule // aen_mix_path

`default_nettype wire

/* hdl/aen_ctrl.sv */
/*
  aen_ctrl: apb register file, enhancement processor run state,
  coefficient store and path controls of the audio enhancement stage.
  assumes: apb master on sys_clk; adc samples synchronous to sys_clk.
*/
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module aen_ctrl
#(
   parameter int ADDR_W     = 18,
   parameter int COEF_SLOTS = aen_pkg::COEF_SLOTS
)
(
   // clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        rst,
   input  wire logic                        clk_en,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [ADDR_W-1:0]           paddr,
   input  wire logic [31:0]                 pwdata,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   // adc sample stream
   input  wire logic                        adc_in_valid,
   input  wire logic [aen_pkg::SAMPLE_W-1:0] adc_in_left,
   input  wire logic [aen_pkg::SAMPLE_W-1:0] adc_in_right,
   output logic                             adc_out_valid,
   output logic [aen_pkg::SAMPLE_W-1:0]     adc_out_left,
   output logic [aen_pkg::SAMPLE_W-1:0]     adc_out_right,
   // path controls
   output logic                             adc_osr_high_select,
   output logic                             proc_running,
   output logic [aen_pkg::ENH_BITS-1:0]     enh_gate,
   output logic                             adc_drc_active,
   output logic                             dac_drc_active,
   output logic                             drc_sidechain_biquad
);

   localparam int WORDS  = COEF_SLOTS / 2;
   localparam int WIDX_W = $clog2(WORDS);

   // ***************************************
   // apb decode
   // ***************************************
   wire logic [15:0] idx;
   wire logic        aligned;
   wire logic        access;
   wire logic        wr_en;
   wire logic        in_coef;
   wire logic [15:0] coef_slot;
   wire logic        coef_low;
   wire logic [WIDX_W-1:0] coef_word;
   wire logic        hit_known;
   wire logic        mapped;

   assign idx       = 16'(paddr[ADDR_W-1:2]);
   assign aligned   = (paddr[1:0] == 2'h0);
   assign access    = psel & penable & pready;
   assign in_coef   = (idx >= aen_pkg::IDX_COEF_FIRST) && (idx <= aen_pkg::IDX_COEF_LAST);
   assign coef_slot = idx - aen_pkg::IDX_COEF_FIRST;
   assign coef_low  = coef_slot[0];
   assign coef_word = coef_slot[WIDX_W:1];
   assign hit_known = (idx == aen_pkg::IDX_ADC_EXTRA) || (idx == aen_pkg::IDX_WIDEN)
                    || (idx == aen_pkg::IDX_PROC_PWR) || (idx == aen_pkg::IDX_PROC_EXEC)
                    || (idx == aen_pkg::IDX_ROUTE) || (idx == aen_pkg::IDX_STATUS)
                    || (idx == aen_pkg::IDX_ENH_EN);
   assign mapped    = aligned & (hit_known | in_coef);
   assign wr_en     = access & pwrite & mapped;

   wire logic wr_adc_extra;
   wire logic wr_widen;
   wire logic wr_proc_pwr;
   wire logic wr_exec;
   wire logic wr_route;
   wire logic wr_enh;
   wire logic wr_coef_hi;
   wire logic wr_coef_lo;

   assign wr_adc_extra = wr_en & (idx == aen_pkg::IDX_ADC_EXTRA);
   assign wr_widen     = wr_en & (idx == aen_pkg::IDX_WIDEN);
   assign wr_proc_pwr  = wr_en & (idx == aen_pkg::IDX_PROC_PWR);
   assign wr_exec      = wr_en & (idx == aen_pkg::IDX_PROC_EXEC);
   assign wr_route     = wr_en & (idx == aen_pkg::IDX_ROUTE);
   assign wr_enh       = wr_en & (idx == aen_pkg::IDX_ENH_EN);
   assign wr_coef_hi   = wr_en & in_coef & ~coef_low;
   assign wr_coef_lo   = wr_en & in_coef & coef_low;

   // ***************************************
   // control registers
   // ***************************************
   logic [15:0]                  adc_extra_control_one_reg;
   logic [15:0]                  widening_control_one_reg;
   logic                         enh_processor_enable_reg;
   logic                         run_reg;
   logic [2:0]                   route_reg;
   logic [aen_pkg::ENH_BITS-1:0] enh_enable_reg;

   wire logic run_cmd;
   wire logic stop_cmd;
   wire logic run_next;
   assign run_cmd  = wr_exec & pwdata[aen_pkg::BIT_RUN_CMD];
   assign stop_cmd = wr_exec & pwdata[aen_pkg::BIT_STOP_CMD];
   // stop wins over run in one write; dropping the enable also stops it
   assign run_next = stop_cmd ? 1'b0 :
                     run_cmd  ? 1'b1 :
                     run_reg & enh_processor_enable_reg;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         adc_extra_control_one_reg <= aen_pkg::RST_ADC_EXTRA;
         widening_control_one_reg  <= aen_pkg::RST_WIDEN;
         enh_processor_enable_reg  <= aen_pkg::RST_PROC_EN;
         run_reg                   <= 1'b0;
         route_reg                 <= aen_pkg::RST_ROUTE;
         enh_enable_reg            <= aen_pkg::RST_ENH_EN;
      end
      else if (clk_en)
      begin
         if (wr_adc_extra)
            adc_extra_control_one_reg <= pwdata[15:0];
         if (wr_widen)
            widening_control_one_reg <= pwdata[15:0];
         if (wr_proc_pwr)
            enh_processor_enable_reg <= pwdata[aen_pkg::BIT_PROC_EN];
         if (wr_route)
            route_reg <= pwdata[2:0];
         if (wr_enh)
            enh_enable_reg <= pwdata[aen_pkg::ENH_BITS-1:0];
         run_reg <= run_next;
      end
   end

   // ***************************************
   // coefficient store
   // ***************************************
   // the msb byte waits in a holding register until the low slot arrives,
   // so a word is committed whole; a low write without it reuses the last held msb byte
   logic [23:0] coef_mem [WORDS];
   logic [7:0]  coef_hold_reg;
   logic        coef_pending_reg;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         coef_hold_reg    <= 8'h00;
         coef_pending_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         if (wr_coef_hi)
         begin
            coef_hold_reg    <= pwdata[7:0];
            coef_pending_reg <= 1'b1;
         end
         else if (wr_coef_lo)
            coef_pending_reg <= 1'b0;
      end
   end

   // no reset on storage: it is a memory, contents are host loaded
   always_ff @(posedge sys_clk)
   begin
      if (clk_en && wr_coef_lo)
         coef_mem[coef_word] <= {coef_hold_reg, pwdata[15:0]};
   end

   // ***************************************
   // derived path controls
   // ***************************************
   wire logic                         proc_live;
   wire logic                         other_enh;
   wire logic [aen_pkg::ENH_BITS-1:0] gate_next;
   wire logic                         drc_dac_next;
   wire logic                         drc_adc_next;
   wire logic                         sidechain_next;
   wire logic                         widen_on;
   wire logic                         monomix_next;

   assign proc_live = enh_processor_enable_reg & run_reg;
   assign other_enh = enh_enable_reg[aen_pkg::ENH_ADC_FLAT] | enh_enable_reg[aen_pkg::ENH_DAC_FLAT]
                    | enh_enable_reg[aen_pkg::ENH_BASS] | enh_enable_reg[aen_pkg::ENH_VSS];

   genvar g;
   generate
      for (g = 0; g < aen_pkg::ENH_BITS; g++)
      begin : gen_gate
         // high-pass gates are blocked unless a stage other than the two high-pass ones is on
         if (g == aen_pkg::ENH_HPF_A || g == aen_pkg::ENH_HPF_B)
            assign gate_next[g] = proc_live & enh_enable_reg[g] & other_enh;
         else
            assign gate_next[g] = proc_live & enh_enable_reg[g];
      end
   endgenerate

   // one select bit places the controller, so both paths can never run it
   assign drc_dac_next   = route_reg[aen_pkg::BIT_DRC_EN] & route_reg[aen_pkg::BIT_DRC_IN_DAC];
   assign drc_adc_next   = route_reg[aen_pkg::BIT_DRC_EN] & ~route_reg[aen_pkg::BIT_DRC_IN_DAC];
   assign sidechain_next = drc_adc_next & route_reg[aen_pkg::BIT_DRC_SIDECHN];
   assign widen_on       = widening_control_one_reg[aen_pkg::BIT_WIDEN_EN];
   assign monomix_next   = widening_control_one_reg[aen_pkg::BIT_MONOMIX] & ~widen_on;

   logic                         osr_reg;
   logic                         running_out_reg;
   logic [aen_pkg::ENH_BITS-1:0] gate_reg;
   logic                         drc_adc_reg;
   logic                         drc_dac_reg;
   logic                         sidechain_reg;
   logic                         monomix_reg;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         osr_reg         <= 1'b0;
         running_out_reg <= 1'b0;
         gate_reg        <= '0;
         drc_adc_reg     <= 1'b0;
         drc_dac_reg     <= 1'b0;
         sidechain_reg   <= 1'b0;
         monomix_reg     <= 1'b0;
      end
      else if (clk_en)
      begin
         osr_reg         <= adc_extra_control_one_reg[aen_pkg::BIT_OSR_HIGH];
         running_out_reg <= proc_live;
         gate_reg        <= gate_next;
         drc_adc_reg     <= drc_adc_next;
         drc_dac_reg     <= drc_dac_next;
         sidechain_reg   <= sidechain_next;
         monomix_reg     <= monomix_next;
      end
   end

   assign adc_osr_high_select  = osr_reg;
   assign proc_running         = running_out_reg;
   assign enh_gate             = gate_reg;
   assign adc_drc_active       = drc_adc_reg;
   assign dac_drc_active       = drc_dac_reg;
   assign drc_sidechain_biquad = sidechain_reg;

   // ***************************************
   // adc mix path
   // ***************************************
   aen_if mix_bus ();

   assign mix_bus.in_valid   = adc_in_valid;
   assign mix_bus.in_left    = adc_in_left;
   assign mix_bus.in_right   = adc_in_right;
   assign mix_bus.monomix_on = monomix_reg;

   aen_mix_path u_mix
   (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clk_en  (clk_en),
      .mp      (mix_bus.path)
   );

   assign adc_out_valid = mix_bus.out_valid;
   assign adc_out_left  = mix_bus.out_left;
   assign adc_out_right = mix_bus.out_right;

   // ***************************************
   // read mux and apb answer
   // ***************************************
   // no wait state: data is registered in the setup cycle
   wire logic [15:0] status_word;
   wire logic [23:0] coef_rd;
   logic     [31:0]  rd_mux;

   assign status_word = {10'h000, coef_pending_reg, sidechain_reg, drc_dac_reg,
                         drc_adc_reg, monomix_reg, proc_live};
   assign coef_rd     = coef_mem[coef_word];

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (in_coef)
         rd_mux = coef_low ? {16'h0000, coef_rd[15:0]} : {24'h00_0000, coef_rd[23:16]};
      else
      begin
         case (idx)
            aen_pkg::IDX_ADC_EXTRA: rd_mux = {16'h0000, adc_extra_control_one_reg};
            aen_pkg::IDX_WIDEN:     rd_mux = {16'h0000, widening_control_one_reg};
            aen_pkg::IDX_PROC_PWR:  rd_mux = {31'h0000_0000, enh_processor_enable_reg};
            aen_pkg::IDX_ROUTE:     rd_mux = {29'h0000_0000, route_reg};
            aen_pkg::IDX_STATUS:    rd_mux = {16'h0000, status_word};
            aen_pkg::IDX_ENH_EN:    rd_mux = {26'h000_0000, enh_enable_reg};
            default:                rd_mux = 32'h0000_0000;      // exec register reads 0
         endcase
      end
   end

   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         pready_reg  <= psel & ~penable;
         pslverr_reg <= psel & ~penable & ~mapped;
         if (psel & ~penable)
            prdata_reg <= mapped ? rd_mux : 32'h0000_0000;
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;

endmodule // aen_ctrl

`default_nettype wire

/* verif/aen_ctrl_assertions.sv */
/*
  aen_ctrl_assertions: port-level checks of aen_ctrl.
  assumes: bound to aen_ctrl, clk_en held high.
*/
`timescale 1ns/100ps
`default_nettype none

module aen_ctrl_assertions
#(
   parameter int ADDR_W = 18
)
(
   // clock and reset
   input wire logic              sys_clk,
   input wire logic              rst,
   // apb
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // stream and controls
   input wire logic              adc_in_valid,
   input wire logic              adc_out_valid,
   input wire logic              adc_osr_high_select,
   input wire logic              proc_running,
   input wire logic [5:0]        enh_gate,
   input wire logic              adc_drc_active,
   input wire logic              dac_drc_active,
   input wire logic              drc_sidechain_biquad
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // ***************************************
   // checks
   // ***************************************
   property p_ready_after_setup;
      psel && !penable |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("no answer after setup");
   property p_ready_one;
      pready |=> !pready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("answer longer than one cycle");
   property p_slverr;
      pslverr |-> pready;
   endproperty
   a_slverr: assert property (p_slverr) else $error("error without answer");
   property p_osr;
      psel && penable && pready && pwrite && paddr == ADDR_W'(32'h5c)
      |-> ##2 adc_osr_high_select == $past(pwdata[5], 2);
   endproperty
   a_osr: assert property (p_osr) else $error("oversampling select mismatch");
   property p_out_valid;
      adc_in_valid |=> adc_out_valid ##1 !adc_out_valid;
   endproperty
   a_out_valid: assert property (p_out_valid) else $error("sample pulse mismatch");
   property p_drc_excl;
      !(adc_drc_active && dac_drc_active);
   endproperty
   a_drc_excl: assert property (p_drc_excl) else $error("dynamics in both paths");
   property p_side;
      drc_sidechain_biquad |-> adc_drc_active && !dac_drc_active;
   endproperty
   a_side: assert property (p_side) else $error("side chain outside adc path");
   property p_hpf_alone;
      enh_gate[3] || enh_gate[4] |-> enh_gate[0] || enh_gate[1] || enh_gate[2] || enh_gate[5];
   endproperty
   a_hpf_alone: assert property (p_hpf_alone) else $error("high-pass gate alone");
   property p_gate_run;
      |enh_gate |-> proc_running;
   endproperty
   a_gate_run: assert property (p_gate_run) else $error("gate open while not running");
   property p_stop;
      psel && penable && pready && pwrite && paddr == ADDR_W'(32'h1034) && pwdata[2]
      |-> ##2 !proc_running && enh_gate == 6'h00;
   endproperty
   a_stop: assert property (p_stop) else $error("still running after stop");
endmodule // aen_ctrl_assertions

`default_nettype wire

/* verif/aen_ctrl_tb.sv */
/*
  aen_ctrl_tb: register-level tests of aen_ctrl over apb.
  assumes: design files compiled first; clk_en tied high.
*/
`timescale 1ns/100ps
`default_nettype none

module aen_ctrl_tb;
   localparam int AW = 18;
   logic          sys_clk, rst, psel, penable, pwrite, adc_in_valid, rdy, er;
   logic [AW-1:0] paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic [23:0]   adc_in_left, adc_in_right, out_l, out_r;
   logic          out_v, oversampling_ratio, running, adc_drc, dac_drc, side;
   logic [5:0]    gate;
   int            fail_count = 0;
   int            n_checks = 0;
   logic [15:0]   ridx [5] = '{aen_pkg::IDX_ADC_EXTRA, aen_pkg::IDX_WIDEN, aen_pkg::IDX_PROC_PWR,
                              aen_pkg::IDX_ENH_EN, aen_pkg::IDX_ROUTE};
   logic [5:0]    pat [5] = '{6'h18, 6'h1a, 6'h01, 6'h03, 6'h24};
   logic [5:0]    pexp [5] = '{6'h00, 6'h1a, 6'h01, 6'h03, 6'h24};

   aen_ctrl #(.ADDR_W(AW)) i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(rdy), .pslverr(er), .adc_in_valid(adc_in_valid), .adc_in_left(adc_in_left),
      .adc_in_right(adc_in_right), .adc_out_valid(out_v), .adc_out_left(out_l),
      .adc_out_right(out_r), .adc_osr_high_select(oversampling_ratio), .proc_running(running), .enh_gate(gate),
      .adc_drc_active(adc_drc), .dac_drc_active(dac_drc), .drc_sidechain_biquad(side));

   always #25 sys_clk = ~sys_clk; // block clock stands in for the master clock

   // ***************************************
   // tasks
   // ***************************************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask

   // request held until pready is sampled high or 16 cycles pass
   task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= AW'({idx, 2'b00});
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (rdy !== 1'b1 && n < 16);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk("pready", 32'h1, {31'h0, rdy});
   endtask

   task automatic rdchk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(nm, exp, rd);
   endtask

   // derived outputs follow one edge after the register
   task automatic settle;
      repeat (2) @(negedge sys_clk);
   endtask

   task automatic smp(input logic [23:0] l, input logic [23:0] r, input logic [23:0] el,
                      input logic [23:0] er_);
      @(posedge sys_clk);
      adc_in_valid <= 1'b1;
      adc_in_left  <= l;
      adc_in_right <= r;
      @(posedge sys_clk);
      adc_in_valid <= 1'b0;
      @(negedge sys_clk);
      chk("out valid", 32'h1, {31'h0, out_v});
      chk("out left", {8'h00, el}, {8'h00, out_l});
      chk("out right", {8'h00, er_}, {8'h00, out_r});
   endtask

   task automatic final_report;
      if (fail_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ***************************************
   // tests
   // ***************************************
   initial
   begin
      logic [2:0] rv;
      sys_clk = 1'b0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      adc_in_valid = 1'b0;
      adc_in_left = 24'h0;
      adc_in_right = 24'h0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (ridx[i]) rdchk("reset value", ridx[i], 32'h0);
      apb(1'b1, aen_pkg::IDX_ADC_EXTRA, 32'h20);
      settle();
      chk("osr", 32'h1, {31'h0, oversampling_ratio});
      rdchk("extra", aen_pkg::IDX_ADC_EXTRA, 32'h20);
      apb(1'b1, aen_pkg::IDX_WIDEN, 32'h40);
      settle();
      smp(24'h7fffff, 24'h7fffff, 24'h7fffff, 24'h7fffff);
      smp(24'hfffff0, 24'h000004, 24'hfffffa, 24'hfffffa);
      apb(1'b1, aen_pkg::IDX_WIDEN, 32'h41);
      settle();
      smp(24'h400000, 24'h100000, 24'h400000, 24'h100000);
      for (int r = 0; r < 8; r++)
      begin
         rv = r[2:0];
         apb(1'b1, aen_pkg::IDX_ROUTE, 32'(r));
         settle();
         chk("drc", {29'h0, rv[2] & rv[0] & ~rv[1], rv[0] & rv[1], rv[0] & ~rv[1]},
             {29'h0, side, dac_drc, adc_drc});
      end
      apb(1'b1, aen_pkg::IDX_PROC_PWR, 32'h1);
      apb(1'b1, aen_pkg::IDX_COEF_FIRST, 32'hab);
      apb(1'b1, aen_pkg::IDX_COEF_FIRST + 16'h1, 32'hcdef);
      apb(1'b1, aen_pkg::IDX_COEF_LAST - 16'h1, 32'h12);
      apb(1'b1, aen_pkg::IDX_COEF_LAST, 32'h3456);
      rdchk("coef hi", aen_pkg::IDX_COEF_FIRST, 32'hab);
      rdchk("coef lo", aen_pkg::IDX_COEF_FIRST + 16'h1, 32'hcdef);
      rdchk("last hi", aen_pkg::IDX_COEF_LAST - 16'h1, 32'h12);
      rdchk("last lo", aen_pkg::IDX_COEF_LAST, 32'h3456);
      settle();
      chk("not running", 32'h0, {25'h0, gate, running});
      apb(1'b1, aen_pkg::IDX_PROC_EXEC, 32'h2);
      apb(1'b1, aen_pkg::IDX_ENH_EN, 32'h3f);
      settle();
      chk("running", 32'h1, {31'h0, running});
      chk("gate all", 32'h3f, {26'h0, gate});
      rdchk("exec", aen_pkg::IDX_PROC_EXEC, 32'h0);
      rdchk("status", aen_pkg::IDX_STATUS, 32'h9);
      foreach (pat[i])
      begin
         apb(1'b1, aen_pkg::IDX_ENH_EN, {26'h0, pat[i]});
         settle();
         chk("gate", {26'h0, pexp[i]}, {26'h0, gate});
      end
      apb(1'b1, aen_pkg::IDX_ENH_EN, 32'h0);
      apb(1'b1, aen_pkg::IDX_PROC_EXEC, 32'h6);
      settle();
      chk("stopped", 32'h0, {25'h0, gate, running});
      apb(1'b1, aen_pkg::IDX_ENH_EN, 32'h3f);
      settle();
      chk("gate idle", 32'h0, {26'h0, gate});
      apb(1'b1, aen_pkg::IDX_ENH_EN, 32'h0);
      apb(1'b1, aen_pkg::IDX_PROC_PWR, 32'h0);
      settle();
      chk("disabled", 32'h0, {25'h0, gate, running});
      rdchk("unmapped", 16'h0001, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
      final_report();
   end

   // a hang ends the run as a failure
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      final_report();
   end
endmodule // aen_ctrl_tb

bind aen_ctrl aen_ctrl_assertions #(.ADDR_W(ADDR_W)) i_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .adc_in_valid(adc_in_valid), .adc_out_valid(adc_out_valid),
   .adc_osr_high_select(adc_osr_high_select), .proc_running(proc_running), .enh_gate(enh_gate),
   .adc_drc_active(adc_drc_active), .dac_drc_active(dac_drc_active),
   .drc_sidechain_biquad(drc_sidechain_biquad));

`default_nettype wire
